/* logic/ssf_regs.svh */
`ifndef SSF_REGS_SVH
`define SSF_REGS_SVH

// ==========================================
// register offsets
`define SSF_ADDR_STATUS 3'h0
`define SSF_ADDR_CTRL 3'h1
`define SSF_ADDR_MODE 3'h2
`define SSF_ADDR_TXBUF 3'h3
`define SSF_ADDR_RXBUF 3'h4
`define SSF_ADDR_IRQ_STAT 3'h5
`define SSF_ADDR_IRQ_MASK 3'h6

// ==========================================
// reset values
`define SSF_STATUS_RESET 8'h84
`define SSF_ZERO_BYTE 8'h00

// ==========================================
// serial_status fields
`define SSF_B_TX_BUFFER_EMPTY 7
`define SSF_B_RX_BUFFER_FULL 6
`define SSF_B_OER 5
`define SSF_B_FER 4
`define SSF_B_PER 3
`define SSF_B_TX_END_FLAG 2
`define SSF_B_RX_MULTIPROC_BIT 1
`define SSF_B_TX_MULTIPROC_BIT 0
`define SSF_CLEARABLE 8'hf8

// ==========================================
// serial_control fields
`define SSF_B_TIE 7
`define SSF_B_RIE 6
`define SSF_B_TE 5
`define SSF_B_RE 4
`define SSF_CTRL_MASK 8'hf0

// ==========================================
// mode fields
`define SSF_B_SYNC 7
`define SSF_B_PAR_EN 5
`define SSF_B_PM 4
`define SSF_B_MP 2
`define SSF_MODE_MASK 8'hb4

// ==========================================
// interrupt status and mask fields
`define SSF_EV_TX 0
`define SSF_EV_RX 1
`define SSF_EV_ERR 2
`define SSF_EV_TX_END_FLAG 3
`define SSF_IRQ_MASK_BITS 8'h0f

`endif

/* logic/ssf_pkg.sv */
package ssf_pkg;

  // one received character from the receive shifter
  typedef struct packed {
    logic done;
    logic [7:0] data;
    logic parity;
    logic stop;
    logic mpb;
  } ssf_rx_char_t;

  // all state of the flag block
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] armed;
    logic [7:0] ctrl;
    logic [7:0] mode;
    logic [7:0] tx_buffer;
    logic [7:0] rx_buffer;
    logic [7:0] irq_stat;
    logic [7:0] irq_mask;
    logic [7:0] rd_data;
    logic irq;
    logic tx_irq;
    logic rx_irq;
    logic err_irq;
    logic tx_avail;
    logic tx_halt;
    logic rx_halt;
    logic tx_mpb;
  } ssf_state_t;

endpackage : ssf_pkg

/* logic/ssf_status_flags.sv */
`timescale 1ns/1ps
`include "ssf_regs.svh"
// Overview of operation
// R1 - flags clear by writing 0 only after being read as 1
// R2 - status initialises to 0x84 on reset and in low-power modes
// R3 - tx_buffer_empty sets on shifter load or while tx_enable is clear
// R4 - tx_buffer_empty clears on tx_buffer write or read-then-write-zero
// R5 - rx_buffer_full sets on error-free character, clears on buffer read or clear
// R6 - on error or rx_enable clear, rx_buffer and rx_buffer_full hold
// R7 - overrun sets when a character completes with rx_buffer_full set; data lost
// R8 - overrun halts reception, and transmission in synchronous mode
// R9 - framing error when first stop bit is 0 in asynchronous mode
// R10 - framing error loads buffer without full flag; halts reception, both if sync
// R11 - parity error when ones count mismatches parity_mode in async parity mode
// R12 - parity error loads buffer without full flag; halts reception, both if sync
// R13 - tx_end_flag sets at last bit with empty buffer or tx_enable clear
// R14 - received multiprocessor bit captured into read-only status bit
// R15 - clearing rx_enable leaves error flags and rx_multiproc_bit unchanged
// R16 - tx_multiproc_bit appended only in async multiprocessor transmission
// R17 - tx_empty_irq while tx_buffer_empty and tx_irq_enable are both set
// R18 - rx full and error interrupts while rx_irq_enable and flag are set
// R19 - writing 1 to clear-only flags or writes to read-only bits do nothing
module ssf_status_flags (
  input wire logic CORE_CLK_IN,
  input wire logic RST_IN,
  input wire logic CE_IN,
  input wire logic LOWPWR_IN,
  input wire logic [2:0] BUS_ADDR_IN,
  input wire logic [7:0] BUS_WDATA_IN,
  input wire logic BUS_WR_IN,
  input wire logic BUS_RD_IN,
  input wire logic TX_LOAD_IN,
  input wire logic TX_LAST_BIT_IN,
  input wire ssf_pkg::ssf_rx_char_t RX_CHAR_IN,
  output logic [7:0] BUS_RDATA_OUT,
  output logic [7:0] TX_DATA_OUT,
  output logic TX_MPB_OUT,
  output logic TX_AVAIL_OUT,
  output logic TX_HALT_OUT,
  output logic RX_HALT_OUT,
  output logic TX_EMPTY_IRQ_OUT,
  output logic RX_FULL_IRQ_OUT,
  output logic RX_ERROR_IRQ_OUT,
  output logic IRQ_OUT
);

  // ==========================================
  // address decode
  function automatic logic ssf_hit(input logic [2:0] a, input logic [2:0] r);
    return a == r;
  endfunction : ssf_hit

  ssf_pkg::ssf_state_t state_reg;
  ssf_pkg::ssf_state_t state_next;

  logic wr_status;
  logic rd_status;
  logic wr_txbuf;
  logic rd_rxbuf;
  logic rd_irq;
  logic tx_enable;
  logic rx_enable;
  logic sync_mode;
  logic halt;
  logic rx_take;
  logic fer_ev;
  logic per_ev;
  logic oer_ev;
  logic rx_buffer_full_ev;
  logic load_rx;
  logic tx_buffer_empty_set;
  logic tx_buffer_empty_clr;
  logic tx_end_flag_set;
  logic [7:0] sw_clr;

  assign wr_status = BUS_WR_IN && ssf_hit(BUS_ADDR_IN, `SSF_ADDR_STATUS);
  assign rd_status = BUS_RD_IN && ssf_hit(BUS_ADDR_IN, `SSF_ADDR_STATUS);
  assign wr_txbuf = BUS_WR_IN && ssf_hit(BUS_ADDR_IN, `SSF_ADDR_TXBUF);
  assign rd_rxbuf = BUS_RD_IN && ssf_hit(BUS_ADDR_IN, `SSF_ADDR_RXBUF);
  assign rd_irq = BUS_RD_IN && ssf_hit(BUS_ADDR_IN, `SSF_ADDR_IRQ_STAT);

  assign tx_enable = state_reg.ctrl[`SSF_B_TE];
  assign rx_enable = state_reg.ctrl[`SSF_B_RE];
  assign sync_mode = state_reg.mode[`SSF_B_SYNC];

  // ==========================================
  // receive events
  assign halt = state_reg.status[`SSF_B_OER] | state_reg.status[`SSF_B_FER]
              | state_reg.status[`SSF_B_PER]; // R8 R10 R12
  assign rx_take = RX_CHAR_IN.done && rx_enable && !halt; // R6 R8
  assign oer_ev = rx_take && state_reg.status[`SSF_B_RX_BUFFER_FULL]; // R7
  assign load_rx = rx_take && !state_reg.status[`SSF_B_RX_BUFFER_FULL]; // R7
  assign fer_ev = load_rx && !sync_mode && !RX_CHAR_IN.stop; // R9
  assign per_ev = load_rx && !sync_mode && state_reg.mode[`SSF_B_PAR_EN]
                && ((^{RX_CHAR_IN.data, RX_CHAR_IN.parity})
                    != state_reg.mode[`SSF_B_PM]); // R11
  assign rx_buffer_full_ev = load_rx && !fer_ev && !per_ev; // R5 R6

  // ==========================================
  // transmit events
  assign tx_buffer_empty_set = TX_LOAD_IN || !tx_enable; // R3
  assign sw_clr = (wr_status ? ~BUS_WDATA_IN : `SSF_ZERO_BYTE)
                & state_reg.armed & `SSF_CLEARABLE; // R1 R19
  assign tx_buffer_empty_clr = wr_txbuf || sw_clr[`SSF_B_TX_BUFFER_EMPTY]; // R4
  assign tx_end_flag_set = (TX_LAST_BIT_IN && state_reg.status[`SSF_B_TX_BUFFER_EMPTY])
                  || !tx_enable; // R13

  // ==========================================
  // next state
  always_comb begin
    state_next = state_reg;
    // tx_buffer_empty, set wins over clear
    if (tx_buffer_empty_set) begin
      state_next.status[`SSF_B_TX_BUFFER_EMPTY] = 1'b1; // R3
    end else if (tx_buffer_empty_clr) begin
      state_next.status[`SSF_B_TX_BUFFER_EMPTY] = 1'b0; // R4
    end
    if (tx_end_flag_set) begin
      state_next.status[`SSF_B_TX_END_FLAG] = 1'b1; // R13
    end else if (tx_buffer_empty_clr) begin
      state_next.status[`SSF_B_TX_END_FLAG] = 1'b0; // R13
    end
    // rx_buffer_full
    if (rx_buffer_full_ev) begin
      state_next.status[`SSF_B_RX_BUFFER_FULL] = 1'b1; // R5
    end else if (rd_rxbuf || sw_clr[`SSF_B_RX_BUFFER_FULL]) begin
      state_next.status[`SSF_B_RX_BUFFER_FULL] = 1'b0; // R5
    end
    // error flags are not set while rx_enable is clear; software clear still works
    if (oer_ev) begin
      state_next.status[`SSF_B_OER] = 1'b1; // R7
    end else if (sw_clr[`SSF_B_OER]) begin
      state_next.status[`SSF_B_OER] = 1'b0; // R1
    end
    if (fer_ev) begin
      state_next.status[`SSF_B_FER] = 1'b1; // R9
    end else if (sw_clr[`SSF_B_FER]) begin
      state_next.status[`SSF_B_FER] = 1'b0; // R1
    end
    if (per_ev) begin
      state_next.status[`SSF_B_PER] = 1'b1; // R11
    end else if (sw_clr[`SSF_B_PER]) begin
      state_next.status[`SSF_B_PER] = 1'b0; // R1
    end
    // received data and multiprocessor bit
    if (load_rx) begin
      state_next.rx_buffer = RX_CHAR_IN.data; // R10 R12
      if (!sync_mode && state_reg.mode[`SSF_B_MP]) begin
        state_next.status[`SSF_B_RX_MULTIPROC_BIT] = RX_CHAR_IN.mpb; // R14 R15
      end
    end
    // software writes
    if (wr_status) begin
      state_next.status[`SSF_B_TX_MULTIPROC_BIT] = BUS_WDATA_IN[`SSF_B_TX_MULTIPROC_BIT]; // R19
    end
    if (BUS_WR_IN && ssf_hit(BUS_ADDR_IN, `SSF_ADDR_CTRL)) begin
      state_next.ctrl = BUS_WDATA_IN & `SSF_CTRL_MASK;
    end
    if (BUS_WR_IN && ssf_hit(BUS_ADDR_IN, `SSF_ADDR_MODE)) begin
      state_next.mode = BUS_WDATA_IN & `SSF_MODE_MASK;
    end
    if (wr_txbuf) begin
      state_next.tx_buffer = BUS_WDATA_IN;
    end
    if (BUS_WR_IN && ssf_hit(BUS_ADDR_IN, `SSF_ADDR_IRQ_MASK)) begin
      state_next.irq_mask = BUS_WDATA_IN & `SSF_IRQ_MASK_BITS;
    end
    // low-power entry reinitialises the status register
    if (LOWPWR_IN) begin
      state_next.status = `SSF_STATUS_RESET; // R2
    end
    // a flag is armed for clearing by a read that sees it at 1
    state_next.armed = (state_reg.armed
                       | (rd_status ? state_reg.status : `SSF_ZERO_BYTE))
                     & state_next.status & `SSF_CLEARABLE; // R1
    // sticky interrupt status, read clears, set wins
    state_next.irq_stat = rd_irq ? `SSF_ZERO_BYTE : state_reg.irq_stat;
    state_next.irq_stat[`SSF_EV_TX] = state_next.irq_stat[`SSF_EV_TX]
      | (state_next.status[`SSF_B_TX_BUFFER_EMPTY] & ~state_reg.status[`SSF_B_TX_BUFFER_EMPTY]);
    state_next.irq_stat[`SSF_EV_RX] = state_next.irq_stat[`SSF_EV_RX]
      | (state_next.status[`SSF_B_RX_BUFFER_FULL] & ~state_reg.status[`SSF_B_RX_BUFFER_FULL]);
    state_next.irq_stat[`SSF_EV_ERR] = state_next.irq_stat[`SSF_EV_ERR]
      | oer_ev | fer_ev | per_ev;
    state_next.irq_stat[`SSF_EV_TX_END_FLAG] = state_next.irq_stat[`SSF_EV_TX_END_FLAG]
      | (state_next.status[`SSF_B_TX_END_FLAG] & ~state_reg.status[`SSF_B_TX_END_FLAG]);
    state_next.irq = |(state_next.irq_stat & state_next.irq_mask);
    // level requests
    state_next.tx_irq = state_next.status[`SSF_B_TX_BUFFER_EMPTY]
                      & state_next.ctrl[`SSF_B_TIE]; // R17
    state_next.rx_irq = state_next.status[`SSF_B_RX_BUFFER_FULL]
                      & state_next.ctrl[`SSF_B_RIE]; // R18
    state_next.err_irq = (state_next.status[`SSF_B_OER] | state_next.status[`SSF_B_FER]
                         | state_next.status[`SSF_B_PER])
                       & state_next.ctrl[`SSF_B_RIE]; // R18
    // datapath steering
    state_next.rx_halt = state_next.status[`SSF_B_OER] | state_next.status[`SSF_B_FER]
                       | state_next.status[`SSF_B_PER]; // R8 R10 R12
    state_next.tx_halt = state_next.rx_halt & state_next.mode[`SSF_B_SYNC]; // R8
    state_next.tx_avail = !state_next.status[`SSF_B_TX_BUFFER_EMPTY] && !state_next.tx_halt
                        && state_next.ctrl[`SSF_B_TE];
    state_next.tx_mpb = !state_next.mode[`SSF_B_SYNC] && state_next.mode[`SSF_B_MP]
                      && state_next.status[`SSF_B_TX_MULTIPROC_BIT]; // R16
    // read data, valid in the cycle after the strobe only
    state_next.rd_data = `SSF_ZERO_BYTE;
    if (BUS_RD_IN) begin
      unique case (BUS_ADDR_IN)
        `SSF_ADDR_STATUS: state_next.rd_data = state_reg.status;
        `SSF_ADDR_CTRL: state_next.rd_data = state_reg.ctrl;
        `SSF_ADDR_MODE: state_next.rd_data = state_reg.mode;
        `SSF_ADDR_TXBUF: state_next.rd_data = state_reg.tx_buffer;
        `SSF_ADDR_RXBUF: state_next.rd_data = state_reg.rx_buffer;
        `SSF_ADDR_IRQ_STAT: state_next.rd_data = state_reg.irq_stat;
        `SSF_ADDR_IRQ_MASK: state_next.rd_data = state_reg.irq_mask;
        default: state_next.rd_data = `SSF_ZERO_BYTE;
      endcase
    end
  end

  // ==========================================
  // state register
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state_reg <= '0;
      state_reg.status <= `SSF_STATUS_RESET; // R2
      state_reg.rx_halt <= 1'b0;
    end else if (CE_IN) begin
      state_reg <= state_next;
    end
  end

  // ==========================================
  // outputs
  assign BUS_RDATA_OUT = state_reg.rd_data;
  assign TX_DATA_OUT = state_reg.tx_buffer;
  assign TX_MPB_OUT = state_reg.tx_mpb;
  assign TX_AVAIL_OUT = state_reg.tx_avail;
  assign TX_HALT_OUT = state_reg.tx_halt;
  assign RX_HALT_OUT = state_reg.rx_halt;
  assign TX_EMPTY_IRQ_OUT = state_reg.tx_irq;
  assign RX_FULL_IRQ_OUT = state_reg.rx_irq;
  assign RX_ERROR_IRQ_OUT = state_reg.err_irq;
  assign IRQ_OUT = state_reg.irq;

  // ==========================================
  // assertions
  default clocking cb @(posedge CORE_CLK_IN);
  endclocking
  default disable iff (RST_IN);

  sequence s_read_full;
    CE_IN && rd_status && state_reg.status[`SSF_B_RX_BUFFER_FULL] && !LOWPWR_IN;
  endsequence
  sequence s_write_zero_full;
    CE_IN && wr_status && !BUS_WDATA_IN[`SSF_B_RX_BUFFER_FULL] && !LOWPWR_IN
      && state_reg.status[`SSF_B_RX_BUFFER_FULL] && !rx_buffer_full_ev;
  endsequence

  property p_clear_after_read;
    s_read_full ##2 s_write_zero_full |=> !state_reg.status[`SSF_B_RX_BUFFER_FULL];
  endproperty
  a_clear_after_read: assert property (p_clear_after_read) // R1
    else $error("flag not cleared after read then write zero");

  property p_clear_needs_read;
    CE_IN && wr_status && state_reg.status[`SSF_B_OER] && !LOWPWR_IN
      && !state_reg.armed[`SSF_B_OER] |=> state_reg.status[`SSF_B_OER];
  endproperty
  a_clear_needs_read: assert property (p_clear_needs_read) // R1
    else $error("overrun flag cleared without prior read");

  property p_lowpwr_init;
    CE_IN && LOWPWR_IN |=> state_reg.status == `SSF_STATUS_RESET;
  endproperty
  a_lowpwr_init: assert property (p_lowpwr_init) // R2
    else $error("status not reinitialised in low-power mode");

  property p_tx_buffer_empty_on_load;
    CE_IN && TX_LOAD_IN |=> state_reg.status[`SSF_B_TX_BUFFER_EMPTY] ##1 1'b1;
  endproperty
  a_tx_buffer_empty_on_load: assert property (p_tx_buffer_empty_on_load) // R3
    else $error("tx empty not set on shifter load");

  property p_tx_buffer_empty_clear_on_write;
    CE_IN && wr_txbuf && tx_enable && !TX_LOAD_IN && !LOWPWR_IN && !TX_LAST_BIT_IN
      |=> !state_reg.status[`SSF_B_TX_BUFFER_EMPTY] && !state_reg.status[`SSF_B_TX_END_FLAG];
  endproperty
  a_tx_buffer_empty_clear_on_write: assert property (p_tx_buffer_empty_clear_on_write) // R4
    else $error("tx empty or tx end not cleared by buffer write");

  property p_overrun;
    CE_IN && rx_take && state_reg.status[`SSF_B_RX_BUFFER_FULL] && !LOWPWR_IN
      |=> state_reg.status[`SSF_B_OER] && $stable(state_reg.rx_buffer);
  endproperty
  a_overrun: assert property (p_overrun) // R7
    else $error("overrun not flagged or buffer overwritten");

  property p_framing;
    CE_IN && load_rx && !sync_mode && !RX_CHAR_IN.stop && !LOWPWR_IN
      |=> state_reg.status[`SSF_B_FER] && !state_reg.status[`SSF_B_RX_BUFFER_FULL]
          && state_reg.rx_buffer == $past(RX_CHAR_IN.data);
  endproperty
  a_framing: assert property (p_framing) // R10
    else $error("framing error handling wrong");

  property p_halt_blocks_rx;
    CE_IN && RX_HALT_OUT && RX_CHAR_IN.done && !rd_rxbuf
      |=> $stable(state_reg.rx_buffer) && RX_HALT_OUT == halt;
  endproperty
  a_halt_blocks_rx: assert property (p_halt_blocks_rx) // R8
    else $error("reception continued while halted");

  property p_tx_irq;
    CE_IN && TX_LOAD_IN && state_reg.ctrl[`SSF_B_TIE] && !BUS_WR_IN |=> TX_EMPTY_IRQ_OUT;
  endproperty
  a_tx_irq: assert property (p_tx_irq) // R17
    else $error("tx empty interrupt not raised");

  property p_tx_mpb;
    TX_MPB_OUT |-> !sync_mode && state_reg.mode[`SSF_B_MP];
  endproperty
  a_tx_mpb: assert property (p_tx_mpb) // R16
    else $error("multiprocessor bit sent outside async mp mode");

  property p_rx_buffer_full_set;
    CE_IN && RX_CHAR_IN.done && rx_enable && !halt && !state_reg.status[`SSF_B_RX_BUFFER_FULL]
      && RX_CHAR_IN.stop && !state_reg.mode[`SSF_B_PAR_EN] && !LOWPWR_IN
      |=> state_reg.status[`SSF_B_RX_BUFFER_FULL]
          && state_reg.rx_buffer == $past(RX_CHAR_IN.data);
  endproperty
  a_rx_buffer_full_set: assert property (p_rx_buffer_full_set) // R5
    else $error("rx full not set on clean character");

  property p_tx_end_flag_on_last;
    CE_IN && TX_LAST_BIT_IN && state_reg.status[`SSF_B_TX_BUFFER_EMPTY]
      |=> state_reg.status[`SSF_B_TX_END_FLAG];
  endproperty
  a_tx_end_flag_on_last: assert property (p_tx_end_flag_on_last) // R13
    else $error("tx end not set after last bit");

  property p_tx_disable;
    CE_IN && !tx_enable
      |=> state_reg.status[`SSF_B_TX_BUFFER_EMPTY] && state_reg.status[`SSF_B_TX_END_FLAG];
  endproperty
  a_tx_disable: assert property (p_tx_disable) // R3
    else $error("tx empty or tx end not forced while transmit disabled");

  property p_parity;
    CE_IN && load_rx && !sync_mode && state_reg.mode[`SSF_B_PAR_EN] && !LOWPWR_IN
      && ((^{RX_CHAR_IN.data, RX_CHAR_IN.parity}) != state_reg.mode[`SSF_B_PM])
      |=> state_reg.status[`SSF_B_PER] && !state_reg.status[`SSF_B_RX_BUFFER_FULL]
          && state_reg.rx_buffer == $past(RX_CHAR_IN.data);
  endproperty
  a_parity: assert property (p_parity) // R12
    else $error("parity error handling wrong");

  property p_rx_off_holds;
    CE_IN && !rx_enable && !rd_rxbuf && !wr_status && !LOWPWR_IN
      |=> $stable(state_reg.rx_buffer) && $stable(state_reg.status[`SSF_B_RX_BUFFER_FULL:`SSF_B_PER])
          && $stable(state_reg.status[`SSF_B_RX_MULTIPROC_BIT]);
  endproperty
  a_rx_off_holds: assert property (p_rx_off_holds) // R15
    else $error("receive state changed while receive disabled");

  property p_write_one_keeps;
    CE_IN && wr_status && BUS_WDATA_IN[`SSF_B_OER] && !LOWPWR_IN
      |=> state_reg.status[`SSF_B_OER] || !$past(state_reg.status[`SSF_B_OER]);
  endproperty
  a_write_one_keeps: assert property (p_write_one_keeps) // R19
    else $error("writing one cleared the overrun flag");

  property p_err_irq;
    CE_IN && RX_CHAR_IN.done && rx_enable && !halt && state_reg.status[`SSF_B_RX_BUFFER_FULL]
      && state_reg.ctrl[`SSF_B_RIE] && !BUS_WR_IN && !LOWPWR_IN |=> RX_ERROR_IRQ_OUT;
  endproperty
  a_err_irq: assert property (p_err_irq) // R18
    else $error("receive error interrupt not raised on overrun");

  property p_rx_multiproc_bit_capture;
    CE_IN && load_rx && !sync_mode && state_reg.mode[`SSF_B_MP] && !LOWPWR_IN
      |=> state_reg.status[`SSF_B_RX_MULTIPROC_BIT] == $past(RX_CHAR_IN.mpb);
  endproperty
  a_rx_multiproc_bit_capture: assert property (p_rx_multiproc_bit_capture) // R14
    else $error("received multiprocessor bit not captured");

  property p_tx_avail;
    TX_AVAIL_OUT |-> tx_enable && !state_reg.status[`SSF_B_TX_BUFFER_EMPTY] && !(sync_mode && halt);
  endproperty
  a_tx_avail: assert property (p_tx_avail) // R8
    else $error("transmit offered while empty, disabled or halted");

endmodule : ssf_status_flags

/* test/ssf_far_end.sv */
`timescale 1ns/1ps
// ==========================================
// far end: shifter side of the link
module ssf_far_end #(
  parameter int TX_BITS = 10
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic tx_avail_in,
  input wire logic tx_go_in,
  input wire logic rx_send_in,
  input wire logic [7:0] rx_data_in,
  input wire logic rx_parity_in,
  input wire logic rx_stop_in,
  input wire logic rx_mpb_in,
  output logic tx_load_out,
  output logic tx_last_out,
  output ssf_pkg::ssf_rx_char_t rx_char_out
);
  logic [7:0] cnt;
  // transmitter takes a waiting character, then sends its bits
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt <= 8'h00;
      tx_load_out <= 1'b0;
      tx_last_out <= 1'b0;
    end else begin
      tx_load_out <= tx_go_in && tx_avail_in && (cnt == 8'h00) && !tx_load_out;
      tx_last_out <= (cnt == 8'h01);
      if (tx_load_out) begin
        cnt <= 8'(TX_BITS);
      end else if (cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
      end
    end
  end
  // receiver hands over one character; idle fields toggle
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_char_out <= '0;
    end else if (rx_send_in) begin
      rx_char_out <= {1'b1, rx_data_in, rx_parity_in, rx_stop_in, rx_mpb_in};
    end else begin
      rx_char_out <= {1'b0, ~rx_char_out[10:0]};
    end
  end
endmodule : ssf_far_end

/* test/tb_ssf_status_flags.sv */
`timescale 1ns/1ps
`include "ssf_regs.svh"
module tb_ssf_status_flags;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, lowpwr = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00, rdata, txd, v;
  logic wr = 1'b0, rd = 1'b0, tx_load, tx_last, tx_go = 1'b0, rx_send = 1'b0;
  logic [7:0] rx_data = 8'h00;
  logic rx_par = 1'b0, rx_stop = 1'b1, rx_mpb = 1'b0;
  logic tx_mpb, tx_avail, tx_halt, rx_halt, tx_irq, rx_irq, err_irq, irq;
  ssf_pkg::ssf_rx_char_t rx_char;
  int err_total = 0, checks_done = 0;
  logic [7:0] tbl [5][6];
  always #4 clk = ~clk;
  ssf_status_flags u_dut (.CORE_CLK_IN(clk), .RST_IN(rst), .CE_IN(ce), .LOWPWR_IN(lowpwr),
    .BUS_ADDR_IN(addr), .BUS_WDATA_IN(wdata), .BUS_WR_IN(wr), .BUS_RD_IN(rd),
    .TX_LOAD_IN(tx_load), .TX_LAST_BIT_IN(tx_last), .RX_CHAR_IN(rx_char),
    .BUS_RDATA_OUT(rdata), .TX_DATA_OUT(txd), .TX_MPB_OUT(tx_mpb), .TX_AVAIL_OUT(tx_avail),
    .TX_HALT_OUT(tx_halt), .RX_HALT_OUT(rx_halt), .TX_EMPTY_IRQ_OUT(tx_irq),
    .RX_FULL_IRQ_OUT(rx_irq), .RX_ERROR_IRQ_OUT(err_irq), .IRQ_OUT(irq));
  ssf_far_end u_far (.clk_in(clk), .rst_in(rst), .tx_avail_in(tx_avail), .tx_go_in(tx_go),
    .rx_send_in(rx_send), .rx_data_in(rx_data), .rx_parity_in(rx_par),
    .rx_stop_in(rx_stop), .rx_mpb_in(rx_mpb), .tx_load_out(tx_load),
    .tx_last_out(tx_last), .rx_char_out(rx_char));
  // ==========================================
  // report helpers
  task automatic give_verdict();
    if (err_total == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // ==========================================
  // register bus and link tasks
  task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : bus_wr
  task automatic bus_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : bus_rd
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d;
    bus_rd(a, d);
    chk(d, exp);
  endtask : rd_chk
  task automatic send(input logic [7:0] d, input logic p, input logic s, input logic m);
    @(posedge clk);
    rx_send <= 1'b1;
    rx_data <= d;
    rx_par <= p;
    rx_stop <= s;
    rx_mpb <= m;
    @(posedge clk);
    rx_send <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : send
  task automatic wait_last();
    int n;
    n = 0;
    while (tx_last !== 1'b1 && n < 64) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 64) begin
      err_total++;
      give_verdict();
    end
    @(posedge clk);
    #1;
  endtask : wait_last
  // ==========================================
  // main sequence
  initial begin
    tbl = '{'{8'h00, 8'h5a, 8'h0, 8'h0, 8'h94, 8'h5a}, '{8'h20, 8'h01, 8'h0, 8'h1, 8'h8c, 8'h01},
      '{8'h30, 8'h07, 8'h0, 8'h1, 8'h84, 8'h07}, '{8'h30, 8'h03, 8'h0, 8'h1, 8'h8c, 8'h03},
      '{8'h80, 8'h44, 8'h0, 8'h0, 8'hc4, 8'h44}};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd_chk(`SSF_ADDR_STATUS, 8'h84);
    chk({7'h0, irq}, 8'h00);
    bus_wr(`SSF_ADDR_CTRL, 8'ha0);
    chk({7'h0, tx_irq}, 8'h01);
    bus_wr(`SSF_ADDR_TXBUF, 8'h3c);
    chk({7'h0, tx_avail}, 8'h01);
    rd_chk(`SSF_ADDR_STATUS, 8'h00);
    chk({7'h0, tx_irq}, 8'h00);
    tx_go <= 1'b1;
    wait_last();
    tx_go <= 1'b0;
    chk(txd, 8'h3c);
    rd_chk(`SSF_ADDR_STATUS, 8'h84);
    bus_wr(`SSF_ADDR_TXBUF, 8'h5c);
    bus_wr(`SSF_ADDR_STATUS, 8'h00);
    rd_chk(`SSF_ADDR_STATUS, 8'h00);
    bus_wr(`SSF_ADDR_CTRL, 8'h80);
    @(posedge clk);
    #1;
    chk({7'h0, tx_irq}, 8'h01);
    bus_wr(`SSF_ADDR_CTRL, 8'h20);
    bus_wr(`SSF_ADDR_STATUS, 8'h00);
    rd_chk(`SSF_ADDR_STATUS, 8'h84);
    bus_wr(`SSF_ADDR_STATUS, 8'h00);
    rd_chk(`SSF_ADDR_STATUS, 8'h00);
    bus_wr(`SSF_ADDR_CTRL, 8'h50);
    bus_wr(`SSF_ADDR_MODE, 8'h04);
    send(8'h55, 1'b0, 1'b1, 1'b1);
    rd_chk(`SSF_ADDR_STATUS, 8'hc6);
    chk({7'h0, rx_irq}, 8'h01);
    rd_chk(`SSF_ADDR_RXBUF, 8'h55);
    rd_chk(`SSF_ADDR_STATUS, 8'h86);
    send(8'h11, 1'b0, 1'b1, 1'b0);
    send(8'h22, 1'b0, 1'b1, 1'b1);
    rd_chk(`SSF_ADDR_STATUS, 8'he4);
    chk({6'h0, err_irq, rx_halt}, 8'h03);
    send(8'h33, 1'b0, 1'b1, 1'b0);
    rd_chk(`SSF_ADDR_RXBUF, 8'h11);
    bus_wr(`SSF_ADDR_CTRL, 8'h40);
    rd_chk(`SSF_ADDR_STATUS, 8'ha4);
    bus_wr(`SSF_ADDR_STATUS, 8'hfa);
    rd_chk(`SSF_ADDR_STATUS, 8'ha4);
    bus_wr(`SSF_ADDR_STATUS, 8'h00);
    rd_chk(`SSF_ADDR_STATUS, 8'h84);
    bus_wr(`SSF_ADDR_CTRL, 8'h50);
    for (int i = 0; i < 5; i++) begin
      bus_wr(`SSF_ADDR_MODE, tbl[i][0]);
      send(tbl[i][1], tbl[i][2][0], tbl[i][3][0], 1'b0);
      rd_chk(`SSF_ADDR_RXBUF, tbl[i][5]);
      rd_chk(`SSF_ADDR_STATUS, tbl[i][4] & ((i == 4) ? 8'hbf : 8'hff));
      bus_wr(`SSF_ADDR_STATUS, 8'h00);
      rd_chk(`SSF_ADDR_STATUS, 8'h84);
    end
    send(8'h12, 1'b0, 1'b1, 1'b0);
    send(8'h13, 1'b0, 1'b1, 1'b0);
    chk({6'h0, tx_halt, rx_halt}, 8'h03);
    bus_wr(`SSF_ADDR_STATUS, 8'h00);
    rd_chk(`SSF_ADDR_STATUS, 8'he4);
    bus_wr(`SSF_ADDR_STATUS, 8'h00);
    chk({6'h0, tx_halt, rx_halt}, 8'h00);
    bus_wr(`SSF_ADDR_MODE, 8'h04);
    bus_wr(`SSF_ADDR_STATUS, 8'h81);
    chk({7'h0, tx_mpb}, 8'h01);
    bus_wr(`SSF_ADDR_MODE, 8'h84);
    chk({7'h0, tx_mpb}, 8'h00);
    bus_rd(`SSF_ADDR_IRQ_STAT, v);
    bus_wr(`SSF_ADDR_IRQ_MASK, 8'h00);
    send(8'h77, 1'b0, 1'b1, 1'b0);
    chk({7'h0, irq}, 8'h00);
    bus_wr(`SSF_ADDR_IRQ_MASK, 8'h02);
    chk({7'h0, irq}, 8'h01);
    rd_chk(`SSF_ADDR_IRQ_STAT, 8'h02);
    chk({7'h0, irq}, 8'h00);
    bus_wr(3'h7, 8'hff);
    rd_chk(3'h7, 8'h00);
    bus_wr(`SSF_ADDR_CTRL, 8'h20);
    bus_wr(`SSF_ADDR_TXBUF, 8'h01);
    @(posedge clk);
    lowpwr <= 1'b1;
    repeat (2) @(posedge clk);
    lowpwr <= 1'b0;
    rd_chk(`SSF_ADDR_STATUS, 8'h84);
    give_verdict();
  end
endmodule : tb_ssf_status_flags
